// File: hdl/ssp_cfg.svh
// constants for the switch serial register port
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// ----------------------------------------------------------
// word layout
// ----------------------------------------------------------
`define SSP_WORD_W      16
`define SSP_BIT_WD      15
`define SSP_BIT_PAR     14
`define SSP_BIT_BANK    13
`define SSP_ADDR_HI     12
`define SSP_ADDR_LO     10
`define SSP_PAY_HI      9
`define SSP_SEL_HI      2
`define SSP_CNT_W       8
`define SSP_LEN_HI      3
// ----------------------------------------------------------
// input register addresses
// ----------------------------------------------------------
`define SSP_A_STAT      3'h0
`define SSP_A_DUTY      3'h1
`define SSP_A_CONF      3'h2
`define SSP_A_OVC       3'h4
`define SSP_A_RETRY     3'h5
`define SSP_A_GLOB      3'h6
`define SSP_A_CAL       3'h7
`define SSP_CAL_PAT     10'h15B
// ----------------------------------------------------------
// readback select codes (bank bit on top)
// ----------------------------------------------------------
`define SSP_S_STAT      4'h0
`define SSP_S_FAULT     3'h1
`define SSP_S_DUTY      3'h2
`define SSP_S_CONF      3'h3
`define SSP_S_OVC       3'h4
`define SSP_S_RETRY     3'h5
`define SSP_S_GLOB      4'h6
`define SSP_S_DIAG      4'h7
// ----------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------
`define SSP_GLOB_PARALLEL 6
`define SSP_GLOB_FAIL_EN  3
`define SSP_RETRY_OFP    8
`define SSP_REG_RST     10'h000
`define SSP_TX_RST      16'h0000
`endif

// File: hdl/ssp_pkg.sv
// types shared by the switch serial register port
package ssp_pkg;
    // monitored device state, same clock as the port
    typedef struct packed {
        logic            ov;
        logic            uv;
        logic [1:0]      r_full;
        logic [1:0]      fault;
        logic [1:0]      out;
        logic            temp_warn_raw;
        logic [1:0][5:0] ch_fault;
        logic [1:0][3:0] retry_cnt;
        logic [1:0]      conf;
        logic [1:0]      id;
        logic [1:0]      in;
        logic            clock_fail;
        logic [1:0]      cal_fail;
    } ssp_mon_t;
    // register contents handed to the switch core
    typedef struct packed {
        logic [1:0][9:0] duty_cycle_control;
        logic [1:0][9:0] channel_configuration;
        logic [1:0][9:0] overcurrent_configuration;
        logic [1:0][9:0] retry_control;
        logic [9:0]      global_configuration;
    } ssp_regs_t;
endpackage

// File: hdl/ssp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
module ssp_sync #(
    parameter int  W       = 1,
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;  // first stage, read only by q

    // ----------------------------------------------------------
    // two stage capture
    // ----------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{RST_VAL}};
            q    <= {W{RST_VAL}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// File: hdl/ssp_top.sv
// serial command and readback port of a dual high-side switch
// Function
// - shift out MSB first while sampling input
// - first word is register chosen previously
// - latch input word only at select release
// - write only whole sixteen-multiple, good parity
// - after latch, output floats, status refreshed
// - extra bits pass through one word late
// - second word out equals first word in
// - whole word must hold even ones
// - bank, address, payload decoded from word
// - address codes map to seven input registers
// - status write payload picks next readback
// - returned word carries echo, flags, select
// - resets clear registers, parallel bit may survive
// - power-on flag kept over supply failure in fail-safe
// - serial traffic ignored while reset pin low
// - warning flag clears only on later read
`timescale 1ns/1ns
`include "ssp_cfg.svh"
module ssp_top (
    // system clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // serial link, master side clock
    input  wire logic              spi_clk,
    input  wire logic              chip_select_n,
    input  wire logic              serial_in,
    output logic                   serial_out,
    output logic                   serial_out_oe_n,
    // device pins and supervisors
    input  wire logic              reset_n,
    input  wire logic              supply_fail,
    input  wire logic              normal_mode_flag,
    // device state and configuration
    input  wire ssp_pkg::ssp_mon_t mon,
    output ssp_pkg::ssp_regs_t     regs,
    output logic [1:0]             calibration_trigger
);
    import ssp_pkg::*;

    // ----------------------------------------------------------
    // declarations
    // ----------------------------------------------------------
    logic [1:0]           rst_pipe;     // reset release stages
    logic                 rst_n;        // released reset copy
    logic [15:0]          shift_reg;    // link shift register
    logic [`SSP_CNT_W-1:0] bit_cnt;     // free running bit count
    logic                 first_bit;    // no edge yet this frame
    logic [15:0]          tx_word;      // word offered to link
    logic                 cs_s;         // select, synchronised
    logic                 cs_d;         // previous select
    logic                 rst_pin_s;    // reset pin, synchronised
    logic                 fail_s;       // supply fail, sync
    logic                 fail_d;       // previous supply fail
    logic [`SSP_CNT_W-1:0] cnt_seen;    // count at last frame
    logic [`SSP_CNT_W-1:0] cnt_diff;    // bits in this frame
    logic                 frame_end;    // select just released
    logic                 len_ok;       // whole words clocked
    logic                 par_ok;       // even ones in word
    logic                 accept;       // word will be latched
    logic                 fail_evt;     // supply just failed
    logic                 keep_par;     // fail-safe enabled
    logic [15:0]          rx;           // received word
    logic                 bank;         // bank select bit
    logic [2:0]           addr;         // register address
    logic [9:0]           pay;          // payload
    logic [3:0]           readback_select;
    logic                 watchdog_toggle_bit;
    logic                 parity_fault_flag;
    logic                 overtemp_warning_flag;
    logic                 por_pend;     // set at power up until reset pin seen high
    logic                 por_flag;     // power-on flag
    logic                 fault_read;   // fault word went out
    logic                 stat_read;    // status word went out

    // ----------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------
    // even count of ones over the whole word
    function automatic logic even_ones(input logic [15:0] w);
        even_ones = ~(^w);
    endfunction

    // pack one returned word from its data field
    function automatic logic [15:0] pack_word(
        input logic       wd,
        input logic       perr,
        input logic [3:0] sel,
        input logic       nmode,
        input logic [8:0] data
    );
        pack_word = {wd, perr, sel, nmode, data};
    endfunction

    // ----------------------------------------------------------
    // reset release
    // ----------------------------------------------------------
    // assert at once, release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ----------------------------------------------------------
    // link side, on the master's clock
    // ----------------------------------------------------------
    // first-edge flag, preset whenever select is high
    always_ff @(posedge spi_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            first_bit <= 1'b1;
        end else begin
            first_bit <= 1'b0;
        end
    end

    // shift register and bit count; count clears only on arst_n so the
    // value survives select release for the other domain
    always_ff @(posedge spi_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= `SSP_TX_RST;
            bit_cnt   <= '0;
        end else if (!chip_select_n) begin
            if (first_bit) begin
                shift_reg <= {tx_word[14:0], serial_in};
            end else begin
                shift_reg <= {shift_reg[14:0], serial_in};
            end
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // MSB first, offered word before first edge
    // after sixteen edges the first input word emerges
    assign serial_out = first_bit ? tx_word[15] : shift_reg[15];
    // output floats whenever select is high
    assign serial_out_oe_n = chip_select_n;

    // ----------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------
    ssp_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (chip_select_n),
        .q     (cs_s)
    );

    ssp_sync #(.W(2), .RST_VAL(1'b0)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({reset_n, supply_fail}),
        .q     ({rst_pin_s, fail_s})
    );

    // edge history of the synchronised pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_d   <= 1'b1;
            fail_d <= 1'b0;
        end else begin
            cs_d   <= cs_s;
            fail_d <= fail_s;
        end
    end

    // ----------------------------------------------------------
    // frame check on select release
    // ----------------------------------------------------------
    // link is idle once select is high, so its words are stable
    assign frame_end = cs_s & ~cs_d;
    assign rx        = shift_reg;
    assign cnt_diff  = bit_cnt - cnt_seen;
    // length must be a non-empty multiple of sixteen
    assign len_ok    = (cnt_diff[`SSP_LEN_HI:0] == 4'h0) &&
                       (cnt_diff != '0);
    // odd ones count is a parity error
    assign par_ok    = even_ones(rx);
    // nothing taken while reset pin is low
    assign accept    = frame_end & len_ok & par_ok & rst_pin_s;
    assign fail_evt  = fail_s & ~fail_d;
    assign keep_par  = regs.global_configuration[`SSP_GLOB_FAIL_EN];

    // split word into bank, address, payload
    assign bank = rx[`SSP_BIT_BANK];
    assign addr = rx[`SSP_ADDR_HI:`SSP_ADDR_LO];
    assign pay  = rx[`SSP_PAY_HI:0];

    // count seen at each release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_seen <= '0;
        end else if (frame_end) begin
            cnt_seen <= bit_cnt;
        end
    end

    // parity outcome of last whole-length frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parity_fault_flag <= 1'b0;
        end else if (!rst_pin_s) begin
            parity_fault_flag <= 1'b0;
        end else if (frame_end && len_ok) begin
            parity_fault_flag <= ~par_ok;
        end
    end

    // watchdog echo of last accepted word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_toggle_bit <= 1'b0;
        end else if (!rst_pin_s || fail_evt) begin
            watchdog_toggle_bit <= 1'b0;
        end else if (accept) begin
            watchdog_toggle_bit <= rx[`SSP_BIT_WD];
        end
    end

    // ----------------------------------------------------------
    // input registers
    // ----------------------------------------------------------
    // pin reset clears all, supply failure all but the parallel bit in fail-safe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs <= '0;
        end else if (!rst_pin_s || fail_evt) begin
            regs <= '0;
            // parallel bit kept if fail-safe enabled
            if (fail_evt && rst_pin_s && keep_par) begin
                regs.global_configuration[`SSP_GLOB_PARALLEL] <=
                    regs.global_configuration[`SSP_GLOB_PARALLEL];
            end
        end else if (accept) begin
            if (addr == `SSP_A_DUTY) begin
                regs.duty_cycle_control[bank] <= pay;
            end else if (addr == `SSP_A_CONF) begin
                regs.channel_configuration[bank] <= pay;
            end else if (addr == `SSP_A_OVC) begin
                regs.overcurrent_configuration[bank] <= pay;
            end else if (addr == `SSP_A_RETRY) begin
                regs.retry_control[bank] <= pay;
            end else if (addr == `SSP_A_GLOB && !bank) begin
                // global register lives in bank 0 only
                regs.global_configuration <= pay;
            end
        end
    end

    // status write picks next readback source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_select <= `SSP_S_STAT;
        end else if (!rst_pin_s || fail_evt) begin
            readback_select <= `SSP_S_STAT;
        end else if (accept && addr == `SSP_A_STAT) begin
            readback_select <= {bank, pay[`SSP_SEL_HI:0]};
        end
    end

    // calibration fires only on its fixed pattern
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calibration_trigger <= 2'h0;
        end else begin
            calibration_trigger <= 2'h0;
            if (accept && addr == `SSP_A_CAL &&
                pay == `SSP_CAL_PAT) begin
                calibration_trigger[bank] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------
    // sticky flags
    // ----------------------------------------------------------
    // which word went out in the frame just ended
    assign fault_read = frame_end && len_ok &&
                        readback_select[2:0] == `SSP_S_FAULT;
    assign stat_read  = frame_end && len_ok &&
                        readback_select == `SSP_S_STAT;

    // warning clears on read once cause is gone; set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_warning_flag <= 1'b0;
        end else if (mon.temp_warn_raw) begin
            overtemp_warning_flag <= 1'b1;
        end else if (fault_read) begin
            overtemp_warning_flag <= 1'b0;
        end
    end

    // power-on flag raised once after power-up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_pend <= 1'b1;
        end else if (rst_pin_s) begin
            // held until the pin reset is seen high
            por_pend <= 1'b0;
        end
    end

    // flag survives supply failure in fail-safe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_flag <= 1'b0;
        end else if (!rst_pin_s) begin
            por_flag <= 1'b0;
        end else if (por_pend) begin
            por_flag <= 1'b1;
        end else if (fail_evt && !keep_par) begin
            por_flag <= 1'b0;
        end else if (stat_read) begin
            por_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // readback word
    // ----------------------------------------------------------
    // data field per select code
    function automatic logic [8:0] sel_data(input logic [3:0] s);
        logic       b;
        logic [9:0] w;
        b = s[3];
        w = `SSP_REG_RST;
        if (s == `SSP_S_STAT) begin
            w = {1'b0, mon.ov, mon.uv, por_flag, mon.r_full,
                 mon.fault, mon.out};
        end else if (s[2:0] == `SSP_S_FAULT) begin
            w = {1'b0, overtemp_warning_flag, 2'h0,
                 mon.ch_fault[b]};
        end else if (s[2:0] == `SSP_S_DUTY) begin
            w = regs.duty_cycle_control[b];
        end else if (s[2:0] == `SSP_S_CONF) begin
            w = regs.channel_configuration[b];
        end else if (s[2:0] == `SSP_S_OVC) begin
            w = regs.overcurrent_configuration[b];
        end else if (s[2:0] == `SSP_S_RETRY) begin
            w = {1'b0, regs.retry_control[b][`SSP_RETRY_OFP],
                 mon.retry_cnt[b], regs.retry_control[b][3:0]};
        end else if (s == `SSP_S_GLOB) begin
            w = regs.global_configuration;
        end else if (s == `SSP_S_DIAG) begin
            w = {1'b0, mon.conf, mon.id, mon.in,
                 mon.clock_fail, mon.cal_fail};
        end
        sel_data = w[8:0];
    endfunction

    // word chosen by the last status write
    // refreshed only while select is high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_word <= `SSP_TX_RST;
        end else if (cs_s && cs_d) begin
            tx_word <= pack_word(watchdog_toggle_bit,
                                 parity_fault_flag,
                                 readback_select,
                                 normal_mode_flag,
                                 sel_data(readback_select));
        end
    end
endmodule

// File: sim/ssp_props.sv
// assertion checker for the switch serial register port
`timescale 1ns/1ns
module ssp_props (
    // clock and reset
    input wire logic               clk,
    input wire logic               arst_n,
    // serial link
    input wire logic               spi_clk,
    input wire logic               chip_select_n,
    input wire logic               serial_in,
    input wire logic               serial_out,
    input wire logic               serial_out_oe_n,
    // pins, state and registers
    input wire logic               reset_n,
    input wire logic               supply_fail,
    input wire logic               normal_mode_flag,
    input wire ssp_pkg::ssp_mon_t  mon,
    input wire ssp_pkg::ssp_regs_t regs,
    input wire logic [1:0]         calibration_trigger
);
    import ssp_pkg::*;
    logic [3:0]  hi_cnt; // clk cycles since select rose
    logic [7:0]  n_bits; // link edges in this frame
    logic [15:0] hist;   // recent input bits
    // ------------------------------------------
    // helpers
    // ------------------------------------------
    // saturates so long idle gaps never wrap
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt <= 4'h0;
        end else if (!chip_select_n) begin
            hi_cnt <= 4'h0;
        end else if (hi_cnt != 4'hF) begin
            hi_cnt <= hi_cnt + 4'h1;
        end
    end
    // link clock is still between frames, so clear on select
    always_ff @(posedge spi_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            n_bits <= 8'h00;
        end else if (n_bits != 8'hFF) begin
            n_bits <= n_bits + 8'h01;
        end
    end
    // input history, valid once sixteen edges passed
    always_ff @(posedge spi_clk) begin
        hist <= {hist[14:0], serial_in};
    end
    // ------------------------------------------
    // assertions
    // ------------------------------------------
    a_oe_follows_cs:
        assert property (@(posedge clk) disable iff (!arst_n)
            serial_out_oe_n == chip_select_n)
        else $error("output enable differs from select");
    a_regs_after_cs:
        assert property (@(posedge clk) disable iff (!arst_n)
            !$stable(regs) && reset_n && $past(reset_n, 6) && !supply_fail
            && !$past(supply_fail, 6) |-> hi_cnt >= 4'h2 && hi_cnt <= 4'h8)
        else $error("register changed outside a frame end");
    a_cal_window:
        assert property (@(posedge clk) disable iff (!arst_n)
            calibration_trigger != 2'b00 |-> hi_cnt >= 4'h3 && hi_cnt <= 4'h9)
        else $error("calibration pulse outside a frame end");
    a_cal_single:
        assert property (@(posedge clk) disable iff (!arst_n)
            calibration_trigger != 2'b00 |=> calibration_trigger == 2'b00)
        else $error("calibration pulse longer than one cycle");
    a_pin_reset_clear:
        assert property (@(posedge clk) disable iff (!arst_n)
            (!reset_n) [*6] |-> regs == '0 && calibration_trigger == 2'b00)
        else $error("registers not clear while reset pin low");
    a_fail_clear:
        assert property (@(posedge clk) disable iff (!arst_n)
            $rose(supply_fail) |-> ##6 regs[89:10] == '0
            && (regs[9:0] & 10'h3BF) == 10'h000)
        else $error("supply failure left register bits set");
    a_fail_keep_par:
        assert property (@(posedge clk) disable iff (!arst_n)
            $rose(supply_fail) && regs[3] |-> ##6
            regs[6] == $past(regs[6], 6))
        else $error("parallel bit lost on supply failure");
    a_pass_through:
        assert property (@(posedge spi_clk) disable iff (!arst_n)
            !chip_select_n && n_bits >= 8'h10 |-> serial_out == hist[15])
        else $error("serial data not delayed by one word");
    c_cal: cover property (@(posedge clk) calibration_trigger != 2'b00);
    c_fail: cover property (@(posedge clk) $rose(supply_fail));
    c_chain: cover property (@(posedge spi_clk) n_bits == 8'h1F);
endmodule

// File: sim/ssp_spi_mst.sv
// serial master model for the register port
`timescale 1ns/1ns
module ssp_spi_mst (
    // lines toward the device
    output logic      spi_clk,
    output logic      chip_select_n,
    output logic      serial_in,
    // answer from the device
    input wire logic  serial_out,
    input wire logic  serial_out_oe_n
);
    // idle: clock still, select high
    initial begin
        spi_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end
    // ------------------------------------------
    // one frame of n bits, msb first
    // ------------------------------------------
    // select stays low across every word of a chain
    task automatic xfer(input logic [47:0] d, input int n,
                        output logic [47:0] q);
        q = '0;
        chip_select_n = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = d[i];
            #7;
            // a floating output reads as unknown, never as a match
            q = {q[46:0], serial_out_oe_n ? 1'bx : serial_out};
            spi_clk = 1'b1;
            #8;
            spi_clk = 1'b0;
        end
        #8;
        chip_select_n = 1'b1;
        // released line shows the inverse, not the last bit
        serial_in = ~serial_in;
        #40;
    endtask
endmodule

// File: sim/tb_ssp_top.sv
// self-checking bench for the switch serial register port
`timescale 1ns/1ns
module tb_ssp_top;
    import ssp_pkg::*;
    // ------------------------------------------
    // signals
    // ------------------------------------------
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       spi_clk, chip_select_n, serial_in;
    logic       serial_out, serial_out_oe_n;
    logic       reset_n, supply_fail, normal_mode_flag;
    ssp_mon_t   mon;
    ssp_regs_t  regs;
    logic [1:0] cal, cal_seen = 2'b00;
    logic [47:0] q;      // last frame's output bits
    logic       wd = 1'b0; // watchdog bit of last accepted word
    int         n_fail = 0, n_checks = 0, cyc = 0;
    logic [2:0] ad [4] = '{3'h1, 3'h2, 3'h4, 3'h5};
    logic [9:0] pv [8] = '{10'h1A5, 10'h0C3, 10'h155, 10'h0AA,
                           10'h1F0, 10'h00F, 10'h10A, 10'h005};
    logic [3:0] sl [9] = '{4'h2, 4'hA, 4'h3, 4'hB, 4'h4, 4'hC,
                           4'h6, 4'h0, 4'h0};
    always #2 clk = ~clk;
    ssp_top DUT (.*, .calibration_trigger(cal));
    ssp_spi_mst u_mst (.*);
    // sticky record of calibration pulses
    always @(posedge clk) cal_seen <= cal_seen | cal;
    // hang guard, far above the run's length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_fail++;
            stop_test();
        end
    end
    // ------------------------------------------
    // helpers
    // ------------------------------------------
    // parity bit makes the ones count even
    function automatic logic [15:0] mk(input logic w, b,
        logic [2:0] a, logic [9:0] p);
        return {w, ^{w, b, a, p}, b, a, p};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [95:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one frame, then let the clk side settle
    task automatic frm(input logic [47:0] d, input int n);
        u_mst.xfer(d, n, q);
        tick(20);
    endtask
    // accepted words alternate the watchdog bit
    task automatic wr(input logic b, logic [2:0] a, logic [9:0] p);
        wd = ~wd;
        frm({32'h0, mk(wd, b, a, p)}, 16);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial begin
        reset_n = 1'b1;
        supply_fail = 1'b0;
        normal_mode_flag = 1'b1;
        mon = '0;
        tick(6);
        arst_n <= 1'b1;
        tick(10);
        chk({cal, regs}, 0);
        wr(0, 3'h6, 10'h048);
        chk(q[15:0], 16'h0240);
        chk(regs.global_configuration, 10'h048);
        for (int i = 0; i < 8; i++) begin
            wr(i[0], ad[i / 2], pv[i]);
        end
        chk(regs[89:10], {pv[1], pv[0], pv[3], pv[2], pv[5], pv[4],
            pv[7], pv[6]});
        // global register only answers on bank 0
        wr(1, 3'h6, 10'h3FF);
        chk(regs.global_configuration, 10'h048);
        // wrong lengths are dropped; the 17-bit one ends on a valid word
        for (int n = 15; n <= 17; n += 2) begin
            frm({32'h1, mk(~wd, 0, 3'h1, 10'h3FF)}, n);
            chk(regs.duty_cycle_control[0], pv[0]);
        end
        frm({32'h0, mk(~wd, 0, 3'h1, 10'h3FF) ^ 16'h0001}, 16);
        chk(regs.duty_cycle_control[0], pv[0]);
        // each status write picks what the next frame returns
        for (int k = 0; k < 9; k++) begin
            wr(sl[k][3], 3'h0, {7'h0, sl[k][2:0]});
            if (k == 0) begin
                chk(q[14], 1'b1);
            end else begin
                chk(q[15:0], {~wd, 1'b0, sl[k - 1], 1'b1, k < 7 ?
                    pv[k - 1][8:0] : (k == 7 ? 9'h048 : 9'h000)});
            end
        end
        // two words in one frame: first word comes back out
        wd = ~wd;
        frm({16'h0, mk(~wd, 1, 3'h2, 10'h2C7),
            mk(wd, 0, 3'h1, 10'h111)}, 32);
        chk(q[15:0], mk(~wd, 1, 3'h2, 10'h2C7));
        chk(regs.duty_cycle_control[0], 10'h111);
        // warning flag outlives its cause until read
        mon.ch_fault[1] <= 6'h2A;
        mon.temp_warn_raw <= 1'b1;
        wr(1, 3'h0, 10'h001);
        mon.temp_warn_raw <= 1'b0;
        wr(1, 3'h0, 10'h001);
        chk(q[13:0], {4'h9, 1'b1, 9'h12A});
        wr(1, 3'h0, 10'h001);
        chk(q[8:0], 9'h02A);
        wr(1, 3'h7, 10'h15B);
        chk(cal_seen, 2'b10);
        wr(0, 3'h7, 10'h15A);
        chk(cal_seen, 2'b10);
        wr(0, 3'h7, 10'h15B);
        chk(cal_seen, 2'b11);
        // frame sent while the reset pin is low is ignored
        reset_n <= 1'b0;
        tick(10);
        wr(0, 3'h1, 10'h0AB);
        chk(regs, 0);
        reset_n <= 1'b1;
        tick(10);
        wr(0, 3'h6, 10'h048);
        wr(0, 3'h1, 10'h055);
        supply_fail <= 1'b1;
        tick(10);
        chk(regs, {80'h0, 10'h040});
        supply_fail <= 1'b0;
        tick(10);
        // second reset in mid-run
        arst_n <= 1'b0;
        tick(3);
        chk({cal, regs}, 0);
        arst_n <= 1'b1;
        tick(10);
        wr(1, 3'h4, 10'h3C1);
        chk(regs.overcurrent_configuration[1], 10'h3C1);
        stop_test();
    end
endmodule
bind ssp_top ssp_props u_props (.*);
